// *** ncfg_pkg.sv ***
package ncfg_pkg;
    // register indices (printed offsets are indices; byte address is four times)
    localparam logic [7:0] IDX_TX_HIGH = 8'h1D;
    localparam logic [7:0] IDX_TX_LOW = 8'h1E;
    localparam logic [7:0] IDX_PEER_RATE = 8'h1F;
    localparam logic [7:0] IDX_CONV = 8'h20;
    localparam logic [7:0] IDX_TRIM_CTRL = 8'h21;
    localparam logic [7:0] IDX_TARGET = 8'h22;
    localparam logic [7:0] IDX_TRIM_RES = 8'h23;
    localparam logic [7:0] IDX_DEPTH_CTRL = 8'h24;
    localparam logic [7:0] IDX_DEPTH_RES = 8'h25;
    localparam logic [7:0] IDX_MOD_SEG = 8'h26;
    localparam logic [7:0] IDX_NORM_SEG = 8'h27;
    localparam logic [7:0] IDX_THRESH = 8'h29;
    localparam logic [7:0] IDX_REG_CTRL = 8'h2A;
    // bit masks of writable bits, and of used bits for the peer rate and trim result words; zero bits are unused and read zero
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_TRIM_CTRL = 8'hF8;
    localparam logic [7:0] MASK_DEPTH_CTRL = 8'hFE;
    localparam logic [7:0] MASK_THRESH = 8'h7F;
    localparam logic [7:0] MASK_REG_CTRL = 8'hFE;
    localparam logic [7:0] MASK_PEER_RATE = 8'hF0;
    localparam logic [7:0] MASK_TRIM_RES = 8'hF8;
    // defaults
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h80;
    localparam logic [7:0] RST_THRESH = 8'h33;
    localparam logic [7:0] SEG_ALL = 8'hFF;
    // field positions
    localparam int SRC_BIT = 7;
    localparam int TRIM_MSB = 6;
    localparam int TRIM_LSB = 3;
    localparam int TRIM_ERR_BIT = 3;
    localparam int DEPTH_MSB = 6;
    localparam int DEPTH_LSB = 1;
    localparam int REGV_MSB = 6;
    localparam int REGV_LSB = 3;
    localparam int MSEL_MSB = 2;
    localparam int MSEL_LSB = 1;
    localparam int SPLIT_MSB = 2;
    localparam logic [3:0] REGV_MIN = 4'h5;
    localparam logic [3:0] REGV_MAX = 4'hF;
    localparam logic [2:0] SPLIT_NONE = 3'h0;
    localparam logic [12:0] TX_MAX = 13'h1FFF;
endpackage

// *** ncfg_seg_select.sv ***
`timescale 1ns/10ps
`default_nettype none
// picks driver segment disables for the present modulation state
module ncfg_seg_select (
    input wire logic level_source_select,
    input wire logic modulating,
    input wire logic [7:0] cal_seg,
    input wire logic [7:0] man_seg,
    input wire logic [7:0] norm_seg,
    output logic [7:0] seg_off,
    output logic drivers_hiz
);
    // manual or calibrated level while modulating, normal level otherwise
    always_comb begin
        if (modulating) begin
            seg_off = level_source_select ? man_seg : cal_seg;
        end else begin
            seg_off = norm_seg;
        end
    end
    // all segments off in normal state puts drivers in tristate
    assign drivers_hiz = !modulating && (norm_seg == ncfg_pkg::SEG_ALL);
endmodule
`default_nettype wire

// *** ncfg_src_select.sv ***
`timescale 1ns/10ps
`default_nettype none
// chooses manual or command-derived code, without any check of the code
module ncfg_src_select #(
    parameter int W = 4
) (
    input wire logic manual,
    input wire logic [W-1:0] cmd_code,
    input wire logic [W-1:0] man_code,
    output logic [W-1:0] code
);
    if (W < 1) begin
        $error("width too small");
    end
    // bit 7 of the control register steers the mux
    assign code = manual ? man_code : cmd_code;
endmodule
`default_nettype wire

// *** ncfg_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// - hold 13-bit byte count, upper eight in first register, low five in second.
// - bits 2:0 of second count register give final partial byte bit count.
// - a frame ending in partial byte is sent without parity generation.
// - writable registers load defaults at power-up and set-default command.
// - read-only display registers clear at power-up and set-default command.
// - detected peer bit rate sits in bits 7:4; bits 3:0 unused.
// - anticollision set, card idle, split bits nonzero raises parity error on wakeup.
// - latest converter result readable, replaced after each conversion.
// - trim control bit 7 selects calibrated or manual trim switches.
// - manual trim bits 6:3 turn on both trim pin groups when selected.
// - 8-bit calibration target phase, default with only bit 7 set.
// - calibration stores 4-bit switch setting in 7:4, bit 3 on failure.
// - depth control bit 7 picks depth setting or per-segment disables.
// - depth result bits mark disabled segments; all ones on failure.
// - manual modulated level: each set bit disables one segment while modulating.
// - normal-level bits disable segments during unmodulated operation.
// - all ones in normal-level register put drivers in high impedance while not modulating.
// - bits 6:4 pick peer detection threshold, default code 011.
// - bits 3:0 pick collision avoidance threshold, default code 0011.
// - regulator bit 7 picks adjust-command result or manual bits 6:3.
// - bits 2:1 pick supply sampled by measure-supply command.
// - regulated voltage code valid from 1111 down to 0101 only.
module ncfg_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic set_default,
    input wire logic rate_valid,
    input wire logic [3:0] rate_code,
    input wire logic conv_done,
    input wire logic [7:0] conv_value,
    input wire logic trim_done,
    input wire logic [3:0] trim_code,
    input wire logic trim_fail,
    input wire logic depth_done,
    input wire logic [7:0] depth_code,
    input wire logic depth_fail,
    input wire logic [3:0] reg_adjust_code,
    input wire logic modulating,
    input wire logic anticoll_enable,
    input wire logic card_idle,
    input wire logic wakeup_issue,
    output logic [12:0] tx_bytes,
    output logic [2:0] tx_split_bits,
    output logic tx_no_parity,
    output logic parity_error_event,
    output logic [3:0] trim_switches,
    output logic [7:0] target_phase,
    output logic [5:0] depth_setting,
    output logic [7:0] seg_off,
    output logic drivers_hiz,
    output logic [2:0] peer_threshold,
    output logic [3:0] ca_threshold,
    output logic [3:0] reg_voltage,
    output logic [1:0] supply_select
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] tx_high;
        logic [7:0] tx_low;
        logic [7:0] peer_rate;
        logic [7:0] conv;
        logic [7:0] trim_ctrl;
        logic [7:0] target;
        logic [7:0] trim_res;
        logic [7:0] depth_ctrl;
        logic [7:0] depth_res;
        logic [7:0] mod_seg;
        logic [7:0] norm_seg;
        logic [7:0] thresh;
        logic [7:0] reg_ctrl;
        logic dph;
        logic dph_write;
        logic [7:0] dph_idx;
        logic [31:0] rdata;
        logic par_evt;
        logic no_parity;
        logic [3:0] trim_sw;
        logic [7:0] seg;
        logic hiz;
        logic [3:0] regv;
    } ncfg_state_type;

    ncfg_state_type state_reg;
    ncfg_state_type state_next;
    logic [3:0] trim_mux;
    logic [3:0] regv_mux;
    logic [7:0] seg_mux;
    logic hiz_mux;

    // byte address to register index
    function automatic logic [7:0] addr_index(input logic [31:0] a);
        return a[9:2];
    endfunction

    // masked write of a byte: only the listed bits change
    function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
        return (old & ~m) | (d & m);
    endfunction

    // true when a manual regulator code is one of the eleven valid ones
    function automatic logic regv_valid(input logic [3:0] c);
        return (c >= ncfg_pkg::REGV_MIN) && (c <= ncfg_pkg::REGV_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // source muxes and segment selection
    ncfg_src_select #(.W(4)) u_trim_src (
        .manual(state_reg.trim_ctrl[ncfg_pkg::SRC_BIT]),
        .cmd_code(state_reg.trim_res[7:4]),
        .man_code(state_reg.trim_ctrl[ncfg_pkg::TRIM_MSB:ncfg_pkg::TRIM_LSB]),
        .code(trim_mux)
    );

    ncfg_src_select #(.W(4)) u_regv_src (
        .manual(state_reg.reg_ctrl[ncfg_pkg::SRC_BIT]),
        .cmd_code(reg_adjust_code),
        .man_code(state_reg.reg_ctrl[ncfg_pkg::REGV_MSB:ncfg_pkg::REGV_LSB]),
        .code(regv_mux)
    );

    ncfg_seg_select u_seg (
        .level_source_select(state_reg.depth_ctrl[ncfg_pkg::SRC_BIT]),
        .modulating(modulating),
        .cal_seg(state_reg.depth_res),
        .man_seg(state_reg.mod_seg),
        .norm_seg(state_reg.norm_seg),
        .seg_off(seg_mux),
        .drivers_hiz(hiz_mux)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [7:0] d;
        d = hwdata[7:0];
        state_next = state_reg;
        // address phase capture; reads answered from the address-phase address, index kept for writes
        state_next.dph = hsel && hready && htrans[1];
        state_next.dph_write = hwrite;
        state_next.dph_idx = addr_index(haddr);
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (addr_index(haddr))
                ncfg_pkg::IDX_TX_HIGH: state_next.rdata = {24'h000000, state_reg.tx_high};
                ncfg_pkg::IDX_TX_LOW: state_next.rdata = {24'h000000, state_reg.tx_low};
                ncfg_pkg::IDX_PEER_RATE: state_next.rdata = {24'h000000, state_reg.peer_rate};
                ncfg_pkg::IDX_CONV: state_next.rdata = {24'h000000, state_reg.conv};
                ncfg_pkg::IDX_TRIM_CTRL: state_next.rdata = {24'h000000, state_reg.trim_ctrl};
                ncfg_pkg::IDX_TARGET: state_next.rdata = {24'h000000, state_reg.target};
                ncfg_pkg::IDX_TRIM_RES: state_next.rdata = {24'h000000, state_reg.trim_res};
                ncfg_pkg::IDX_DEPTH_CTRL: state_next.rdata = {24'h000000, state_reg.depth_ctrl};
                ncfg_pkg::IDX_DEPTH_RES: state_next.rdata = {24'h000000, state_reg.depth_res};
                ncfg_pkg::IDX_MOD_SEG: state_next.rdata = {24'h000000, state_reg.mod_seg};
                ncfg_pkg::IDX_NORM_SEG: state_next.rdata = {24'h000000, state_reg.norm_seg};
                ncfg_pkg::IDX_THRESH: state_next.rdata = {24'h000000, state_reg.thresh};
                ncfg_pkg::IDX_REG_CTRL: state_next.rdata = {24'h000000, state_reg.reg_ctrl};
                default: state_next.rdata = 32'h00000000; // unmapped reads zero
            endcase
        end
        // data-phase writes; read-only and unused bits are untouched
        if (state_reg.dph && state_reg.dph_write) begin
            unique case (state_reg.dph_idx)
                ncfg_pkg::IDX_TX_HIGH: state_next.tx_high = d;
                ncfg_pkg::IDX_TX_LOW: state_next.tx_low = d;
                ncfg_pkg::IDX_TRIM_CTRL:
                    state_next.trim_ctrl = wmask(state_reg.trim_ctrl, d, ncfg_pkg::MASK_TRIM_CTRL);
                ncfg_pkg::IDX_TARGET: state_next.target = d;
                ncfg_pkg::IDX_DEPTH_CTRL:
                    state_next.depth_ctrl = wmask(state_reg.depth_ctrl, d, ncfg_pkg::MASK_DEPTH_CTRL);
                ncfg_pkg::IDX_MOD_SEG: state_next.mod_seg = d;
                ncfg_pkg::IDX_NORM_SEG: state_next.norm_seg = d;
                ncfg_pkg::IDX_THRESH:
                    state_next.thresh = wmask(state_reg.thresh, d, ncfg_pkg::MASK_THRESH);
                ncfg_pkg::IDX_REG_CTRL: begin
                    // an invalid manual voltage code is refused, keeping the old byte
                    if (regv_valid(d[ncfg_pkg::REGV_MSB:ncfg_pkg::REGV_LSB])) begin
                        state_next.reg_ctrl = wmask(state_reg.reg_ctrl, d, ncfg_pkg::MASK_REG_CTRL);
                    end
                end
                default: ;
            endcase
        end
        // display registers follow the analog and command results
        if (rate_valid) begin
            state_next.peer_rate = {rate_code, 4'h0};
        end
        if (conv_done) begin
            state_next.conv = conv_value;
        end
        if (trim_done) begin
            state_next.trim_res = {trim_code, trim_fail, 3'h0};
        end
        if (depth_done) begin
            state_next.depth_res = depth_fail ? ncfg_pkg::SEG_ALL : depth_code;
        end
        // derived outputs, registered
        // taken from the register in effect, so after a restore the flag lags the cleared register by one cycle
        state_next.no_parity = state_reg.tx_low[ncfg_pkg::SPLIT_MSB:0] != ncfg_pkg::SPLIT_NONE;
        state_next.par_evt = anticoll_enable && card_idle && wakeup_issue
            && (state_reg.tx_low[ncfg_pkg::SPLIT_MSB:0] != ncfg_pkg::SPLIT_NONE);
        state_next.trim_sw = trim_mux;
        state_next.seg = seg_mux;
        state_next.hiz = hiz_mux;
        state_next.regv = regv_mux;
        // set-default command restores every register
        if (set_default) begin
            state_next.tx_high = ncfg_pkg::RST_ZERO;
            state_next.tx_low = ncfg_pkg::RST_ZERO;
            state_next.trim_ctrl = ncfg_pkg::RST_ZERO;
            state_next.target = ncfg_pkg::RST_TARGET;
            state_next.depth_ctrl = ncfg_pkg::RST_ZERO;
            state_next.mod_seg = ncfg_pkg::RST_ZERO;
            state_next.norm_seg = ncfg_pkg::RST_ZERO;
            state_next.thresh = ncfg_pkg::RST_THRESH;
            state_next.reg_ctrl = ncfg_pkg::RST_ZERO;
            state_next.peer_rate = ncfg_pkg::RST_ZERO;
            state_next.conv = ncfg_pkg::RST_ZERO;
            state_next.trim_res = ncfg_pkg::RST_ZERO;
            state_next.depth_res = ncfg_pkg::RST_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.target <= ncfg_pkg::RST_TARGET;
            state_reg.thresh <= ncfg_pkg::RST_THRESH;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops; bus ready and response tied to constants
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign tx_bytes = {state_reg.tx_high, state_reg.tx_low[7:3]};
    assign tx_split_bits = state_reg.tx_low[ncfg_pkg::SPLIT_MSB:0];
    assign tx_no_parity = state_reg.no_parity;
    assign parity_error_event = state_reg.par_evt;
    assign trim_switches = state_reg.trim_sw;
    assign target_phase = state_reg.target;
    assign depth_setting = state_reg.depth_ctrl[ncfg_pkg::DEPTH_MSB:ncfg_pkg::DEPTH_LSB];
    assign seg_off = state_reg.seg;
    assign drivers_hiz = state_reg.hiz;
    assign peer_threshold = state_reg.thresh[6:4];
    assign ca_threshold = state_reg.thresh[3:0];
    assign reg_voltage = state_reg.regv;
    assign supply_select = state_reg.reg_ctrl[ncfg_pkg::MSEL_MSB:ncfg_pkg::MSEL_LSB];

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_default_target: assert property (@(posedge clock) disable iff (rst)
        $past(set_default) |-> state_reg.target == ncfg_pkg::RST_TARGET)
        else $error("target default not restored");
    chk_display_clear: assert property (@(posedge clock) disable iff (rst)
        $past(set_default) |-> state_reg.conv == 8'h00 && state_reg.depth_res == 8'h00)
        else $error("display not cleared");
    chk_rate_low_zero: assert property (@(posedge clock) disable iff (rst)
        state_reg.peer_rate[3:0] == 4'h0)
        else $error("peer rate low bits nonzero");
    chk_conv_update: assert property (@(posedge clock) disable iff (rst)
        conv_done && !set_default |=> state_reg.conv == $past(conv_value))
        else $error("converter result not stored");
    chk_trim_result: assert property (@(posedge clock) disable iff (rst)
        trim_done && !set_default |=> state_reg.trim_res == {$past(trim_code), $past(trim_fail), 3'h0})
        else $error("trim result not stored");
    chk_depth_fail_ones: assert property (@(posedge clock) disable iff (rst)
        depth_done && depth_fail && !set_default |=> state_reg.depth_res == 8'hFF)
        else $error("depth failure not all ones");
    chk_readonly_write: assert property (@(posedge clock) disable iff (rst)
        state_reg.dph && state_reg.dph_write && state_reg.dph_idx == ncfg_pkg::IDX_CONV && !conv_done && !set_default
        |=> $stable(state_reg.conv))
        else $error("read-only word written");
    chk_unused_zero: assert property (@(posedge clock) disable iff (rst)
        state_reg.trim_ctrl[2:0] == 3'h0 && state_reg.thresh[7] == 1'b0 && state_reg.reg_ctrl[0] == 1'b0
        && state_reg.depth_ctrl[0] == 1'b0)
        else $error("unused bit set");

    // framing flags
    chk_no_parity_split: assert property (@(posedge clock) disable iff (rst)
        tx_no_parity == ($past(tx_split_bits) != 3'h0))
        else $error("parity suppression wrong");
    chk_parity_evt: assert property (@(posedge clock) disable iff (rst)
        anticoll_enable && card_idle && wakeup_issue && tx_split_bits != 3'h0 |=> parity_error_event)
        else $error("parity error not raised");

    // sources and segments, one cycle behind their controls; manual voltage code range checked in the same cycle
    chk_trim_calib: assert property (@(posedge clock) disable iff (rst)
        !state_reg.trim_ctrl[7] |=> trim_switches == $past(state_reg.trim_res[7:4]))
        else $error("calibrated trim not applied");
    chk_manual_trim: assert property (@(posedge clock) disable iff (rst)
        state_reg.trim_ctrl[7] && $stable(state_reg.trim_ctrl) |=> trim_switches == $past(state_reg.trim_ctrl[6:3]))
        else $error("manual trim not applied");
    chk_seg_calib: assert property (@(posedge clock) disable iff (rst)
        modulating && !state_reg.depth_ctrl[7] |=> seg_off == $past(state_reg.depth_res))
        else $error("calibrated level not applied");
    chk_seg_manual: assert property (@(posedge clock) disable iff (rst)
        modulating && state_reg.depth_ctrl[7] |=> seg_off == $past(state_reg.mod_seg))
        else $error("manual level not applied");
    chk_seg_normal: assert property (@(posedge clock) disable iff (rst)
        !modulating |=> seg_off == $past(state_reg.norm_seg))
        else $error("normal level not applied");
    chk_hiz_drive: assert property (@(posedge clock) disable iff (rst)
        !modulating && state_reg.norm_seg == 8'hFF |=> drivers_hiz)
        else $error("drivers not tristated");
    chk_hiz_modulating: assert property (@(posedge clock) disable iff (rst)
        modulating |=> !drivers_hiz)
        else $error("drivers tristated while modulating");
    chk_regv_manual: assert property (@(posedge clock) disable iff (rst)
        state_reg.reg_ctrl[7] |=> reg_voltage == $past(state_reg.reg_ctrl[6:3]))
        else $error("manual voltage not applied");
    chk_regv_valid: assert property (@(posedge clock) disable iff (rst)
        state_reg.reg_ctrl[7] |-> state_reg.reg_ctrl[6:3] >= 4'h5)
        else $error("invalid manual voltage code");

    // main scenarios
    cov_write_tx: cover property (@(posedge clock) state_reg.dph && state_reg.dph_write
        && state_reg.dph_idx == ncfg_pkg::IDX_TX_LOW);
    cov_trim_fail: cover property (@(posedge clock) trim_done && trim_fail);
    cov_manual_mod: cover property (@(posedge clock) modulating && state_reg.depth_ctrl[7]);
    cov_set_default: cover property (@(posedge clock) set_default);
    cov_parity_event: cover property (@(posedge clock) parity_error_event);
endmodule
`default_nettype wire

// *** ncfg_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// bus master in the place of the host controller; single whole-word transfers
module ncfg_host_model (
    input wire logic clock,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // address phase held until accepted, then data phase until accepted
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata; // stale data is never left standing
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? {24'h000000, d} : ~hwdata;
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module testbench;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, set_default;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, supply_select;
    logic [2:0] hsize, tx_split_bits, peer_threshold;
    logic rate_valid, conv_done, trim_done, trim_fail, depth_done, depth_fail;
    logic [3:0] rate_code, trim_code, reg_adjust_code, trim_switches, ca_threshold, reg_voltage;
    logic [7:0] conv_value, depth_code, target_phase, seg_off;
    logic modulating, anticoll_enable, card_idle, wakeup_issue, tx_no_parity, parity_error_event, drivers_hiz;
    logic [12:0] tx_bytes;
    logic [5:0] depth_setting;
    logic [7:0] shadow [0:255];
    logic [7:0] regs [0:13] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
        8'h29, 8'h2A, 8'h28};
    int num_errors = 0;
    int comparisons = 0;

    // the single slave drives the bus ready
    assign hready = hreadyout;

    ncfg_regs ncfg_regs_inst (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .set_default, .rate_valid, .rate_code, .conv_done, .conv_value, .trim_done,
        .trim_code, .trim_fail, .depth_done, .depth_code, .depth_fail, .reg_adjust_code, .modulating,
        .anticoll_enable, .card_idle, .wakeup_issue, .tx_bytes, .tx_split_bits, .tx_no_parity,
        .parity_error_event, .trim_switches, .target_phase, .depth_setting, .seg_off, .drivers_hiz,
        .peer_threshold, .ca_threshold, .reg_voltage, .supply_select);

    ncfg_host_model ncfg_host_model_inst (.clock, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata);

    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable bits of each word; read-only and unmapped words take nothing
    function automatic logic [7:0] wmask(input logic [7:0] i);
        case (i)
            8'h1D, 8'h1E, 8'h22, 8'h26, 8'h27: return 8'hFF;
            8'h21: return 8'hF8;
            8'h24, 8'h2A: return 8'hFE;
            8'h29: return 8'h7F;
            default: return 8'h00;
        endcase
    endfunction

    // power-up and restore values
    function automatic logic [7:0] dflt(input logic [7:0] i);
        return (i == 8'h22) ? 8'h80 : (i == 8'h29) ? 8'h33 : 8'h00;
    endfunction

    // register write; regulator words with an unused voltage code are refused
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] q;
        ncfg_host_model_inst.xfer(1'b1, i, d, q);
        if (i != 8'h2A || d[6:3] >= 4'h5) begin
            shadow[i] = (shadow[i] & ~wmask(i)) | (d & wmask(i));
        end
    endtask

    // register read against the shadow copy
    task automatic rd(input logic [7:0] i);
        logic [31:0] q;
        ncfg_host_model_inst.xfer(1'b0, i, 8'h00, q);
        `CHECK("read", {24'h000000, shadow[i]}, q)
        `CHECK("hresp", 1'b0, hresp)
    endtask

    // one pulse of every hardware result plus new levels
    task automatic hw_update();
        logic [31:0] r;
        r = $urandom;
        {depth_fail, trim_fail, trim_code, rate_code} <= r[9:0];
        conv_value <= r[17:10];
        depth_code <= r[25:18];
        reg_adjust_code <= 4'h5 + (r[29:26] % 4'hB);
        modulating <= r[30];
        {rate_valid, conv_done, trim_done, depth_done} <= 4'hF;
        @(posedge clock);
        {rate_valid, conv_done, trim_done, depth_done} <= 4'h0;
        shadow[8'h1F] = {r[3:0], 4'h0};
        shadow[8'h20] = r[17:10];
        shadow[8'h23] = {r[7:4], r[8], 3'h0};
        shadow[8'h25] = r[9] ? 8'hFF : r[25:18];
        repeat (3) @(posedge clock);
    endtask

    // every control output except parity_error_event against the shadow copy
    task automatic check_outs();
        logic [7:0] s;
        s = !modulating ? shadow[8'h27] : shadow[8'h24][7] ? shadow[8'h26] : shadow[8'h25];
        `CHECK("tx_bytes", {shadow[8'h1D], shadow[8'h1E][7:3]}, tx_bytes)
        `CHECK("split", shadow[8'h1E][2:0], tx_split_bits)
        `CHECK("no_parity", shadow[8'h1E][2:0] != 3'h0, tx_no_parity)
        `CHECK("trim", shadow[8'h21][7] ? shadow[8'h21][6:3] : shadow[8'h23][7:4], trim_switches)
        `CHECK("target", shadow[8'h22], target_phase)
        `CHECK("depth", shadow[8'h24][6:1], depth_setting)
        `CHECK("seg_off", s, seg_off)
        `CHECK("hiz", !modulating && shadow[8'h27] == 8'hFF, drivers_hiz)
        `CHECK("peer_thr", shadow[8'h29][6:4], peer_threshold)
        `CHECK("ca_thr", shadow[8'h29][3:0], ca_threshold)
        `CHECK("voltage", shadow[8'h2A][7] ? shadow[8'h2A][6:3] : reg_adjust_code, reg_voltage)
        `CHECK("supply", shadow[8'h2A][2:1], supply_select)
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst, set_default, rate_valid, conv_done, trim_done, trim_fail, depth_done, depth_fail} = 8'h80;
        {modulating, anticoll_enable, card_idle, wakeup_issue} = 4'h0;
        {rate_code, trim_code, conv_value, depth_code} = 24'h000000;
        reg_adjust_code = 4'hF;
        void'($urandom(32'h11EA10AC));
        for (int k = 0; k < 256; k++) shadow[k] = dflt(8'(k));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int k = 0; k < 14; k++) rd(regs[k]);
        check_outs();
        // largest count, tristate drivers, a refused regulator code
        wr(8'h1D, 8'hFF);
        wr(8'h1E, 8'hFF);
        wr(8'h27, 8'hFF);
        wr(8'h2A, 8'hA0);
        repeat (3) @(posedge clock);
        check_outs();
        for (int k = 0; k < 14; k++) rd(regs[k]);
        // random writes and hardware results
        for (int n = 0; n < 40; n++) begin
            wr(regs[$urandom % 14], 8'($urandom));
            hw_update();
            check_outs();
            rd(regs[$urandom % 14]);
        end
        // every supply selection
        for (int m = 0; m < 4; m++) begin
            wr(8'h2A, {5'h1D, 2'(m), 1'b0});
            repeat (3) @(posedge clock);
            check_outs();
        end
        // parity error event on wake-up only with all three conditions
        for (int c = 0; c < 8; c++) begin
            wr(8'h1E, {5'h00, c[2] ? 3'h5 : 3'h0});
            {card_idle, anticoll_enable} <= 2'(c);
            repeat (3) @(posedge clock);
            wakeup_issue <= 1'b1;
            @(posedge clock);
            wakeup_issue <= 1'b0;
            @(posedge clock);
            `CHECK("parity_event", c == 7, parity_error_event)
        end
        // restore defaults over non-zero contents
        set_default <= 1'b1;
        @(posedge clock);
        set_default <= 1'b0;
        for (int k = 0; k < 256; k++) shadow[k] = dflt(8'(k));
        repeat (3) @(posedge clock);
        check_outs();
        for (int k = 0; k < 14; k++) rd(regs[k]);
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
